// file: include/mac_regs.vh
// Register map and field layout of the multiply-accumulate block
`ifndef MAC_REGS_VH
`define MAC_REGS_VH

`define MODE_CONFIG_ADDR   8'h00
`define BYPASS_CONFIG_ADDR 8'h04
`define LOAD_VALUES_ADDR   8'h08
`define FLAG_STATUS_ADDR   8'h0C
`define RESULT_LOW_ADDR    8'h10
`define RESULT_HIGH_ADDR   8'h14

`define MODE_DOT  0
`define MODE_DUAL 1
`define MODE_FLAG 2
`define MODE_ROM  3
`define MODE_MASK  32'h0000000F
`define MODE_RESET 32'h00000000

`define BYP_B     0
`define BYP_BPIPE 1
`define BYP_D     2
`define BYP_C     3
`define BYP_P     4
`define BYP_PM    5
`define BYP_SRC   6
`define BYP_SHIFT 7
`define BYP_NEG   8
`define BYPASS_MASK  32'h000001FF
`define BYPASS_RESET 32'h00000000

`define LV_ASYNC_BASE 0
`define LV_SYNC_BASE  8
`define LV_PM    0
`define LV_SRC   1
`define LV_SHIFT 3
`define LV_NEG   4
`define LOAD_VALUES_MASK  32'h00001F1F
`define LOAD_VALUES_RESET 32'h00001F1F

`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// file: rtl/pipe_stage.v
// Pipeline register with enable, synchronous load, load-low override and bypass
`timescale 1ns/1ps
module pipe_stage #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Data and controls
  input  wire [WIDTH-1:0] d,
  input  wire             enable,
  input  wire             sync_load_low,
  input  wire [WIDTH-1:0] sync_value,
  input  wire             load_low,
  input  wire [WIDTH-1:0] load_value,
  input  wire             bypass,
  // Stage output
  output wire [WIDTH-1:0] q
);
  reg  [WIDTH-1:0] held;
  wire [WIDTH-1:0] gated;

  assign gated = enable ? (sync_load_low ? d : sync_value) : held; // RULE24

  always @(posedge aclk) begin // RULE18
    if (!aresetn) begin
      held <= {WIDTH{1'b0}};
    end else if (!load_low && !bypass) begin
      held <= load_value; // RULE10
    end else begin
      held <= gated; // RULE24
    end
  end

  // Bypass is transparent under the same gating; load-low acts at once otherwise
  assign q = bypass ? gated : (!load_low ? load_value : held); // RULE24
endmodule

// file: rtl/operand_rom.v
// Constant table and A operand register stage
`timescale 1ns/1ps
module operand_rom #(
  parameter [287:0] INIT_TABLE = 288'h0
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Operand sources
  input  wire [17:0] a_in,
  input  wire        use_table,
  input  wire [3:0]  index,
  // Stage controls
  input  wire        enable,
  input  wire        sync_clear_low,
  input  wire        load_low,
  input  wire        bypass,
  // Selected operand
  output wire [17:0] operand
);
  wire [17:0] table_word;
  wire [17:0] source;

  assign table_word = INIT_TABLE[index * 18 +: 18]; // RULE1 RULE2
  assign source = use_table ? table_word : a_in; // RULE3

  pipe_stage #(.WIDTH(18)) a_stage ( // RULE25
    .aclk(aclk), .aresetn(aresetn), .d(source), .enable(enable),
    .sync_load_low(sync_clear_low), .sync_value(18'h00000), .load_low(load_low),
    .load_value(18'h00000), .bypass(bypass), .q(operand));
endmodule

// file: rtl/mult_accum_rom_operand.v
// Pre-adder, multiply and accumulate block with table operand and AXI4-Lite setup
//
// Contract
// RULE1: Sixteen 18-bit table words from one parameter
// RULE2: Lowest 18 parameter bits form word zero
// RULE3: Table select picks indexed word for A
// RULE4: B registered twice; cascade equals pipeline output
// RULE5: User drives only result or B pipeline
// RULE6: Dot mode sums two 9-bit cross products
// RULE7: Dual mode does two independent 9-bit products
// RULE8: Dual mode needs zero shift, D, C, E
// RULE9: Flag kind selects overflow or carry-out
// RULE10: Load-low clears data, loads inverted controls
// RULE11: Shift operand E right 17, sign extended
// RULE12: Result feedback needs result register in use
// RULE13: Only D and C stages have clears; A, B, B pipeline and result stages here also have sync clears
// RULE14: Cascade input comes from whole cascade output
// RULE15: Cascade output always equals the result
// RULE16: B cascade unconnected or feeds whole B
// RULE17: Pre-adder subtracts D when minus is set
// RULE18: All registers run on one rising clock
// RULE19: Static inputs stay tied during operation
// RULE20: Unused register controls are tied high
// RULE21: Operand E is zero, result, or cascade
// RULE22: Result is C plus E plus product
// RULE23: Flags from 50-bit sum bits 49 to 47
// RULE24: Data stage holds, clears, loads, or bypasses
// RULE25: Table word passes through the A stage
// RULE26: B pipeline stage follows B, own controls
`timescale 1ns/1ps
`include "mac_regs.vh"
module mult_accum_rom_operand #(
  parameter [287:0] INIT_TABLE = 288'h0
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Register bus
  input  wire        awvalid,
  output reg         awready,
  input  wire [7:0]  awaddr,
  input  wire        wvalid,
  output reg         wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  input  wire        arvalid,
  output reg         arready,
  input  wire [7:0]  araddr,
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  // Operand A
  input  wire [17:0] a_in,
  input  wire [3:0]  rom_word_index,
  input  wire        a_bypass,
  input  wire        a_sync_clear_low,
  input  wire        a_enable,
  // Operand B and its pipeline stage
  input  wire [17:0] b_in,
  input  wire        b_sync_clear_low,
  input  wire        b_enable,
  input  wire        b_pipe_sync_clear_low,
  input  wire        b_pipe_enable,
  // Operand D
  input  wire [17:0] d_in,
  input  wire        d_asynchronous_clear_low,
  input  wire        d_sync_clear_low,
  input  wire        d_enable,
  // Operand C and carry
  input  wire        carry_input,
  input  wire [47:0] c_in,
  input  wire        c_asynchronous_clear_low,
  input  wire        c_sync_clear_low,
  input  wire        c_enable,
  // Accumulator cascade
  input  wire [47:0] accum_cascade_in,
  // Result stage controls
  input  wire        p_sync_clear_low,
  input  wire        p_enable,
  // Dynamic controls
  input  wire        preadder_minus,
  input  wire        preadder_minus_sync_load_low,
  input  wire        preadder_minus_enable,
  input  wire [1:0]  operand_e_source,
  input  wire        operand_e_source_sync_load_low,
  input  wire        operand_e_source_enable,
  input  wire        operand_e_shift,
  input  wire        operand_e_shift_sync_load_low,
  input  wire        operand_e_shift_enable,
  input  wire        accumulate_negate,
  input  wire        accumulate_negate_sync_load_low,
  input  wire        accumulate_negate_enable,
  input  wire        async_load_low,
  // Results
  output wire [47:0] result,
  output wire        overflow_carry_flag,
  output wire [17:0] b_pipeline_out,
  output wire [17:0] b_cascade_out,
  output wire [47:0] accum_cascade_out
);
  reg  [31:0] mode_config;
  reg  [31:0] bypass_config;
  reg  [31:0] load_values;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;

  wire [17:0] a_q;
  wire [17:0] b_q;
  wire [17:0] d_q;
  wire [48:0] c_q;
  wire [48:0] p_q;
  wire        pm_q;
  wire [1:0]  src_q;
  wire        shift_q;
  wire        neg_q;

  function [31:0] merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  function [9:0] pre9;
    input [8:0] x;
    input [8:0] y;
    input       minus;
    begin
      pre9 = minus ? ({x[8], x} - {y[8], y}) : ({x[8], x} + {y[8], y}); // RULE17
    end
  endfunction

  function [47:0] shift17;
    input [47:0] x;
    begin
      shift17 = {{17{x[47]}}, x[47:17]}; // RULE11
    end
  endfunction

  // Register bus: write side
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      mode_config <= `MODE_RESET;
      bypass_config <= `BYPASS_RESET;
      load_values <= `LOAD_VALUES_RESET;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (!aw_held && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_held <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (!w_held && !bvalid) begin
        wready <= 1'b1;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        if (aw_addr_q == `MODE_CONFIG_ADDR) begin
          mode_config <= merge(mode_config, wdata_q, wstrb_q) & `MODE_MASK;
        end else if (aw_addr_q == `BYPASS_CONFIG_ADDR) begin
          bypass_config <= merge(bypass_config, wdata_q, wstrb_q) & `BYPASS_MASK;
        end else if (aw_addr_q == `LOAD_VALUES_ADDR) begin
          load_values <= merge(load_values, wdata_q, wstrb_q) & `LOAD_VALUES_MASK;
        end else if (aw_addr_q == `FLAG_STATUS_ADDR || aw_addr_q == `RESULT_LOW_ADDR ||
                     aw_addr_q == `RESULT_HIGH_ADDR) begin
          bresp <= `RESP_OKAY;
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Register bus: read decode
  always @* begin
    next_rresp = `RESP_OKAY;
    if (araddr == `MODE_CONFIG_ADDR) begin
      next_rdata = mode_config;
    end else if (araddr == `BYPASS_CONFIG_ADDR) begin
      next_rdata = bypass_config;
    end else if (araddr == `LOAD_VALUES_ADDR) begin
      next_rdata = load_values;
    end else if (araddr == `FLAG_STATUS_ADDR) begin
      next_rdata = {31'h00000000, p_q[48]};
    end else if (araddr == `RESULT_LOW_ADDR) begin
      next_rdata = p_q[31:0];
    end else if (araddr == `RESULT_HIGH_ADDR) begin
      next_rdata = {16'h0000, p_q[47:32]};
    end else begin
      next_rdata = 32'h00000000;
      next_rresp = `RESP_SLVERR;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Operand stages
  operand_rom #(.INIT_TABLE(INIT_TABLE)) a_rom (
    .aclk(aclk), .aresetn(aresetn), .a_in(a_in), .use_table(mode_config[`MODE_ROM]),
    .index(rom_word_index), .enable(a_enable), .sync_clear_low(a_sync_clear_low),
    .load_low(async_load_low), .bypass(a_bypass), .operand(a_q)); // RULE3 RULE10

  pipe_stage #(.WIDTH(18)) b_stage (
    .aclk(aclk), .aresetn(aresetn), .d(b_in), .enable(b_enable),
    .sync_load_low(b_sync_clear_low), .sync_value(18'h00000), .load_low(async_load_low),
    .load_value(18'h00000), .bypass(bypass_config[`BYP_B]), .q(b_q)); // RULE10

  pipe_stage #(.WIDTH(18)) b_pipe_stage ( // RULE4 RULE26
    .aclk(aclk), .aresetn(aresetn), .d(b_q), .enable(b_pipe_enable),
    .sync_load_low(b_pipe_sync_clear_low), .sync_value(18'h00000),
    .load_low(async_load_low), .load_value(18'h00000),
    .bypass(bypass_config[`BYP_BPIPE]), .q(b_pipeline_out));

  pipe_stage #(.WIDTH(18)) d_stage ( // RULE13
    .aclk(aclk), .aresetn(aresetn), .d(d_in), .enable(d_enable),
    .sync_load_low(d_sync_clear_low), .sync_value(18'h00000),
    .load_low(d_asynchronous_clear_low), .load_value(18'h00000),
    .bypass(bypass_config[`BYP_D]), .q(d_q));

  pipe_stage #(.WIDTH(49)) c_stage ( // RULE13
    .aclk(aclk), .aresetn(aresetn), .d({carry_input, c_in}), .enable(c_enable),
    .sync_load_low(c_sync_clear_low), .sync_value(49'h0),
    .load_low(c_asynchronous_clear_low), .load_value(49'h0),
    .bypass(bypass_config[`BYP_C]), .q(c_q));

  // Control stages load the inverse of their stored low-active values
  pipe_stage #(.WIDTH(1)) pm_stage (
    .aclk(aclk), .aresetn(aresetn), .d(preadder_minus), .enable(preadder_minus_enable),
    .sync_load_low(preadder_minus_sync_load_low),
    .sync_value(~load_values[`LV_SYNC_BASE + `LV_PM]), .load_low(async_load_low),
    .load_value(~load_values[`LV_ASYNC_BASE + `LV_PM]), // RULE10
    .bypass(bypass_config[`BYP_PM]), .q(pm_q));

  pipe_stage #(.WIDTH(2)) src_stage (
    .aclk(aclk), .aresetn(aresetn), .d(operand_e_source), .enable(operand_e_source_enable),
    .sync_load_low(operand_e_source_sync_load_low),
    .sync_value(~load_values[`LV_SYNC_BASE + `LV_SRC +: 2]), .load_low(async_load_low),
    .load_value(~load_values[`LV_ASYNC_BASE + `LV_SRC +: 2]), // RULE10
    .bypass(bypass_config[`BYP_SRC]), .q(src_q));

  pipe_stage #(.WIDTH(1)) shift_stage (
    .aclk(aclk), .aresetn(aresetn), .d(operand_e_shift), .enable(operand_e_shift_enable),
    .sync_load_low(operand_e_shift_sync_load_low),
    .sync_value(~load_values[`LV_SYNC_BASE + `LV_SHIFT]), .load_low(async_load_low),
    .load_value(~load_values[`LV_ASYNC_BASE + `LV_SHIFT]), // RULE10
    .bypass(bypass_config[`BYP_SHIFT]), .q(shift_q));

  pipe_stage #(.WIDTH(1)) neg_stage (
    .aclk(aclk), .aresetn(aresetn), .d(accumulate_negate), .enable(accumulate_negate_enable),
    .sync_load_low(accumulate_negate_sync_load_low),
    .sync_value(~load_values[`LV_SYNC_BASE + `LV_NEG]), .load_low(async_load_low),
    .load_value(~load_values[`LV_ASYNC_BASE + `LV_NEG]), // RULE10
    .bypass(bypass_config[`BYP_NEG]), .q(neg_q));

  // Operand E; result feedback relies on the result stage being registered
  wire [47:0] e_raw = src_q[1] ? accum_cascade_in : (src_q[0] ? p_q[47:0] : 48'h0); // RULE21 RULE12
  wire [47:0] e_val = (shift_q && (src_q != 2'b00)) ? shift17(e_raw) : e_raw; // RULE11

  // Normal mode
  wire signed [18:0] pre_full = pm_q ? ($signed({b_q[17], b_q}) - $signed({d_q[17], d_q}))
                                     : ($signed({b_q[17], b_q}) + $signed({d_q[17], d_q})); // RULE17
  wire signed [36:0] prod_full = pre_full * $signed(a_q);
  wire [49:0] c50 = {{2{c_q[47]}}, c_q[47:0]};
  wire [49:0] e50 = {{2{e_val[47]}}, e_val};
  wire [49:0] cin50 = {49'h0, c_q[48]};
  wire [49:0] base50 = cin50 + c50 + e50;
  wire [49:0] norm_term = {{13{prod_full[36]}}, prod_full};
  wire [49:0] sum_norm = neg_q ? (base50 - norm_term) : (base50 + norm_term); // RULE22

  // Dot-product mode
  wire [9:0] pre_lo = pre9(b_q[8:0], d_q[8:0], pm_q);
  wire [9:0] pre_hi = pre9(b_q[17:9], d_q[17:9], pm_q);
  wire signed [18:0] cross_lo = $signed(pre_lo) * $signed(a_q[17:9]);
  wire signed [18:0] cross_hi = $signed(pre_hi) * $signed(a_q[8:0]);
  wire signed [19:0] dot = neg_q ? (cross_lo - cross_hi) : (cross_lo + cross_hi); // RULE6
  wire [49:0] sum_dot = base50 + {{21{dot[19]}}, dot, 9'h000}; // RULE6 RULE22

  // Dual mode splits the sum at bit 18
  wire signed [17:0] dual_lo_prod = $signed(b_q[8:0]) * $signed(a_q[8:0]);
  wire signed [18:0] dual_hi_prod = $signed(pre_hi) * $signed(a_q[17:9]);
  wire [17:0] dual_lo = {17'h00000, c_q[48]} + dual_lo_prod; // RULE7
  wire [31:0] c_hi = {{2{c_q[47]}}, c_q[47:18]};
  wire [31:0] e_hi = {{2{e_val[47]}}, e_val[47:18]};
  wire [31:0] hi_term = {{13{dual_hi_prod[18]}}, dual_hi_prod};
  wire [31:0] dual_hi = neg_q ? (c_hi + e_hi - hi_term) : (c_hi + e_hi + hi_term); // RULE7

  wire [49:0] sum = mode_config[`MODE_DUAL] ? {dual_hi, dual_lo} :
                    mode_config[`MODE_DOT] ? sum_dot : sum_norm; // RULE22
  wire flag = mode_config[`MODE_FLAG] ? (c_q[47] ^ e_val[47] ^ sum[48]) // RULE9 RULE23
                                      : ((sum[49] ^ sum[48]) | (sum[48] ^ sum[47]));

  pipe_stage #(.WIDTH(49)) p_stage (
    .aclk(aclk), .aresetn(aresetn), .d({flag, sum[47:0]}), .enable(p_enable),
    .sync_load_low(p_sync_clear_low), .sync_value(49'h0), .load_low(async_load_low),
    .load_value(49'h0), .bypass(bypass_config[`BYP_P]), .q(p_q)); // RULE10

  assign result = p_q[47:0];
  assign overflow_carry_flag = p_q[48];
  assign accum_cascade_out = p_q[47:0]; // RULE15
  assign b_cascade_out = b_pipeline_out; // RULE4
endmodule

// file: verif/neighbour_block.sv
// Neighbouring math block whose registered result feeds this block's cascade input
`timescale 1ns/1ps
module neighbour_block (
  // Clock
  input  wire        aclk,
  // Sum the neighbour produces next
  input  wire [47:0] next_sum,
  // Whole cascade bus toward this block
  output reg  [47:0] cascade_out
);
  always @(posedge aclk) begin
    cascade_out <= next_sum;
  end
endmodule

// file: verif/mult_accum_rom_operand_checker.sv
// Concurrent checks on the ports of the multiply-accumulate block
`timescale 1ns/1ps
module mult_accum_rom_operand_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Watched inputs
  input wire logic        async_load_low,
  input wire logic [17:0] b_in,
  input wire logic        b_enable,
  input wire logic        b_sync_clear_low,
  input wire logic        b_pipe_enable,
  input wire logic        b_pipe_sync_clear_low,
  input wire logic        p_enable,
  input wire logic        p_sync_clear_low,
  input wire logic        awvalid,
  input wire logic        arvalid,
  // Watched outputs
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [47:0] result,
  input wire logic        overflow_carry_flag,
  input wire logic [17:0] b_pipeline_out,
  input wire logic [17:0] b_cascade_out,
  input wire logic [47:0] accum_cascade_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Configured stage bypasses stay off wherever this checker is used, so every stage but A is registered
  chk_bcas_same: assert property (b_cascade_out == b_pipeline_out)
    else $error("b cascade differs from b pipeline");
  chk_ccas_same: assert property (accum_cascade_out == result)
    else $error("accumulator cascade differs from result");
  chk_aload_zero: assert property ((!async_load_low)[*2] |->
    result == 48'h0 && b_pipeline_out == 18'h0 && !overflow_carry_flag)
    else $error("load-low did not clear result and b pipeline");
  chk_bpipe_flow: assert property ((aresetn && async_load_low && b_enable &&
    b_sync_clear_low && b_pipe_enable && b_pipe_sync_clear_low)[*3] |->
    b_pipeline_out == $past(b_in, 2))
    else $error("b pipeline is not b delayed by two stages");
  chk_bpipe_zero: assert property (b_pipe_enable && !b_pipe_sync_clear_low
    |=> b_pipeline_out == 18'h0)
    else $error("b pipeline not cleared");
  chk_bpipe_hold: assert property (async_load_low && !b_pipe_enable ##1 async_load_low
    |-> $stable(b_pipeline_out))
    else $error("b pipeline changed while disabled");
  chk_res_zero: assert property (p_enable && !p_sync_clear_low
    |=> result == 48'h0 && !overflow_carry_flag)
    else $error("result stage not cleared");
  chk_res_hold: assert property (async_load_low && !p_enable ##1 async_load_low
    |-> $stable(result) && $stable(overflow_carry_flag))
    else $error("result changed while disabled");
  chk_write_busy: assert property (awvalid && awready |=> (!awready && !wready)[*2])
    else $error("write accepted again too soon");
  chk_read_next: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not one cycle after address");
endmodule
bind mult_accum_rom_operand mult_accum_rom_operand_checker chk_inst (.*);

// file: verif/mult_accum_rom_operand_tb.sv
// Self-checking bench for the multiply-accumulate block
`timescale 1ns/1ps
module mult_accum_rom_operand_tb;
  function automatic logic [17:0] wd(input logic [3:0] i);
    return {i, 10'h000, i};
  endfunction
  function automatic logic [287:0] mk();
    for (int i = 0; i < 16; i++) mk[i*18 +: 18] = wd(i[3:0]);
  endfunction
  localparam logic [287:0] TBL = mk();
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF, rom_word_index = 4'h0, csl = 4'hF, cen = 4'hF;
  logic [17:0] a_in = 18'h0, b_in = 18'h0, d_in = 18'h0;
  logic [47:0] c_in = 48'h0, nsum = 48'h0;
  logic [4:0]  sclr = 5'h1F, en = 5'h1F;
  logic [1:0]  operand_e_source = 2'h0;
  logic        a_bypass = 1'h0, carry_input = 1'h0, preadder_minus = 1'h0;
  logic        operand_e_shift = 1'h0, accumulate_negate = 1'h0, async_load_low = 1'h1;
  logic        d_asynchronous_clear_low = 1'h1, c_asynchronous_clear_low = 1'h1;
  logic        b_pipe_sync_clear_low = 1'h1, b_pipe_enable = 1'h1;
  wire         awready, wready, bvalid, arready, rvalid, overflow_carry_flag;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [17:0] b_pipeline_out, b_cascade_out;
  wire  [47:0] result, accum_cascade_out, accum_cascade_in;
  // Stage clears and enables, order A, B, D, C, result
  wire a_sync_clear_low = sclr[0], b_sync_clear_low = sclr[1], d_sync_clear_low = sclr[2];
  wire c_sync_clear_low = sclr[3], p_sync_clear_low = sclr[4];
  wire a_enable = en[0], b_enable = en[1], d_enable = en[2];
  wire c_enable = en[3], p_enable = en[4];
  // Control loads and enables, order minus, source, shift, negate
  wire preadder_minus_sync_load_low = csl[0], operand_e_source_sync_load_low = csl[1];
  wire operand_e_shift_sync_load_low = csl[2], accumulate_negate_sync_load_low = csl[3];
  wire preadder_minus_enable = cen[0], operand_e_source_enable = cen[1];
  wire operand_e_shift_enable = cen[2], accumulate_negate_enable = cen[3];
  int          err_total = 0, tests_run = 0;

  mult_accum_rom_operand #(.INIT_TABLE(TBL)) dut (.*);
  neighbour_block nb (.aclk(aclk), .next_sum(nsum), .cascade_out(accum_cascade_in));
  always #12.5 aclk = ~aclk;

  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk(bresp, r);
    bready <= 1'h0;
    tick(1);
  endtask
  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    chk(rdata, e);
    chk(rresp, r);
    rready <= 1'h0;
    tick(1);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task t_regs;
    axr(8'h00, 32'h0, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    axr(8'h08, 32'h1F1F, 2'h0);
    axw(8'h00, 32'hFFFFFFFF, 2'h0);
    axr(8'h00, 32'hF, 2'h0);
    axw(8'h00, 32'h0, 2'h0);
    axw(8'h20, 32'h1, 2'h2);
    axr(8'h20, 32'h0, 2'h2);
    axw(8'h0C, 32'h1, 2'h0);
    axr(8'h0C, 32'h0, 2'h0);
  endtask
  task t_norm;
    logic [47:0] e;
    a_in <= 18'h3FFFD;
    b_in <= 18'h00064;
    d_in <= 18'h00007;
    c_in <= 48'h1000;
    carry_input <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      preadder_minus <= i[0];
      accumulate_negate <= i[1];
      tick(3);
      e = (i[0] ? 93 : 107) * -3;
      e = 48'h1001 + (i[1] ? -e : e);
      chk(result, e);
      chk(accum_cascade_out, e);
    end
    axr(8'h10, 32'h1118, 2'h0);
  endtask
  task t_bpipe;
    b_in <= 18'h2ABCD;
    tick(3);
    chk(b_pipeline_out, 18'h2ABCD);
    b_pipe_enable <= 1'h0;
    b_in <= 18'h01234;
    tick(3);
    chk(b_pipeline_out, 18'h2ABCD);
    b_pipe_enable <= 1'h1;
    b_pipe_sync_clear_low <= 1'h0;
    tick(2);
    chk(b_pipeline_out, 18'h0);
    b_pipe_sync_clear_low <= 1'h1;
    tick(2);
    chk(b_cascade_out, 18'h01234);
  endtask
  task t_gate;
    a_in <= 18'h2;
    b_in <= 18'h3;
    d_in <= 18'h1;
    c_in <= 48'hA;
    carry_input <= 1'h0;
    preadder_minus <= 1'h0;
    accumulate_negate <= 1'h0;
    tick(3);
    chk(result, 18);
    for (int k = 0; k < 5; k++) begin
      sclr <= ~(5'h01 << k);
      tick(3);
      chk(result, k == 0 ? 10 : k == 1 ? 12 : k == 2 ? 16 : k == 3 ? 8 : 0);
      sclr <= 5'h1F;
      tick(3);
    end
    for (int j = 0; j < 2; j++) begin
      en <= j ? 5'h10 : 5'h00;
      a_in <= 18'h5;
      b_in <= 18'h5;
      d_in <= 18'h5;
      c_in <= 48'h0;
      tick(3);
      chk(result, 18);
    end
    en <= 5'h1F;
    tick(3);
    chk(result, 50);
    a_bypass <= 1'h1;
    a_in <= 18'h6;
    tick(2);
    chk(result, 60);
    a_bypass <= 1'h0;
  endtask
  task t_ctl;
    axw(8'h08, 32'h1E1F, 2'h0);
    a_in <= 18'h1;
    b_in <= 18'h7;
    d_in <= 18'h2;
    csl <= 4'h0;
    tick(3);
    chk(result, 5);
    csl <= 4'hF;
    cen <= 4'h0;
    tick(3);
    chk(result, 5);
    cen <= 4'hF;
    tick(3);
    chk(result, 9);
  endtask
  task t_async;
    axw(8'h08, 32'h1F1E, 2'h0);
    cen <= 4'hE;
    c_in <= 48'hA;
    tick(3);
    chk(result, 19);
    async_load_low <= 1'h0;
    tick(2);
    chk(result, 0);
    chk(b_pipeline_out, 0);
    async_load_low <= 1'h1;
    tick(3);
    chk(result, 15);
    d_asynchronous_clear_low <= 1'h0;
    tick(3);
    chk(result, 17);
    c_asynchronous_clear_low <= 1'h0;
    tick(3);
    chk(result, 7);
    d_asynchronous_clear_low <= 1'h1;
    c_asynchronous_clear_low <= 1'h1;
    cen <= 4'hF;
    axw(8'h08, 32'h1F1F, 2'h0);
  endtask
  task t_esrc;
    logic [47:0] e;
    logic [47:0] r0;
    a_in <= 18'h0;
    c_in <= 48'h0;
    nsum <= 48'h800000012345;
    for (int i = 0; i < 3; i++) begin
      operand_e_source <= i == 0 ? 2'h0 : i == 1 ? 2'h3 : 2'h2;
      operand_e_shift <= i != 1;
      tick(3);
      e = i == 0 ? 48'h0 : i == 1 ? nsum : {{17{nsum[47]}}, nsum[47:17]};
      chk(result, e);
    end
    a_in <= 18'h2;
    b_in <= 18'h3;
    d_in <= 18'h0;
    operand_e_source <= 2'h1;
    for (int j = 0; j < 2; j++) begin
      operand_e_shift <= j[0];
      tick(4);
      r0 = result;
      tick(1);
      e = j ? {{17{r0[47]}}, r0[47:17]} + 48'h6 : r0 + 48'h6;
      chk(result, e);
    end
    operand_e_source <= 2'h0;
    operand_e_shift <= 1'h0;
  endtask
  task t_modes;
    axw(8'h00, 32'h1, 2'h0);
    a_in <= {9'h003, 9'h005};
    b_in <= {9'h007, 9'h002};
    d_in <= {9'h001, 9'h001};
    tick(3);
    chk(result, 48'h6200);
    axw(8'h00, 32'h2, 2'h0);
    d_in <= {9'h001, 9'h000};
    carry_input <= 1'h1;
    tick(3);
    chk(result, 48'h60000B);
  endtask
  task t_rom;
    logic [17:0] w;
    axw(8'h00, 32'h8, 2'h0);
    a_in <= 18'h2AAAA;
    b_in <= 18'h1;
    d_in <= 18'h0;
    carry_input <= 1'h0;
    for (int i = 0; i < 16; i++) begin
      rom_word_index <= i[3:0];
      tick(3);
      w = wd(i[3:0]);
      chk(result, {{30{w[17]}}, w});
    end
  endtask
  task t_flag;
    a_in <= 18'h0;
    carry_input <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      axw(8'h00, {29'h0, i[1], 2'h0}, 2'h0);
      c_in <= i[0] ? 48'hFFFFFFFFFFFF : 48'h7FFFFFFFFFFF;
      tick(3);
      chk(overflow_carry_flag, i[1] == i[0]);
      chk(result, i[0] ? 48'h0 : 48'h800000000000);
      if (i == 0) axr(8'h14, 32'h8000, 2'h0);
    end
    axr(8'h0C, 32'h1, 2'h0);
    axw(8'h00, 32'h0, 2'h0);
  endtask

  initial begin
    tick(5000);
    err_total++;
    final_report;
  end
  initial begin
    tick(2);
    aresetn <= 1'h1;
    tick(2);
    t_regs;
    t_norm;
    t_bpipe;
    t_gate;
    t_ctl;
    t_async;
    t_esrc;
    t_modes;
    t_rom;
    t_flag;
    final_report;
  end
endmodule
